// ==== shared/sirq_pkg.sv ====
// constants, register map and bus states of the shared interrupt block
// assumes a 200 MHz bus clock and an APB master on the register side
package sirq_pkg;
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  A_CTRL         = 8'h00;
	localparam logic [7:0]  A_OPT          = 8'h04;
	localparam logic [7:0]  A_TFLG         = 8'h08;
	localparam logic [7:0]  A_TMSK         = 8'h0C;
	localparam logic [7:0]  A_SSTS         = 8'h10;
	localparam logic [7:0]  A_SDAT         = 8'h14;
	localparam logic [7:0]  A_SCTL         = 8'h18;
	localparam logic [7:0]  A_PSTS         = 8'h1C;
	localparam logic [7:0]  A_PDAT         = 8'h20;
	localparam logic [7:0]  A_PDIR         = 8'h24;
	localparam logic [7:0]  A_PEND         = 8'h28;
	localparam int          CTRL_EXP       = 0;
	localparam int          CTRL_MASK      = 1;
	localparam logic        EXP_RST        = 1'b0;
	localparam logic        MASK_RST       = 1'b1;
	localparam int          OPT_EDGE       = 0;
	localparam int          OPT_WIN        = 1;
	localparam logic        EDGE_RST       = 1'b0;
	localparam int          SSTS_RDF       = 0;
	localparam int          SCTL_RIE       = 0;
	localparam int          PSTS_FLAG      = 0;
	localparam int          PSTS_IE        = 1;
	localparam int          TIMER_N        = 4;
	localparam int          PIO_W          = 8;
	localparam int          HS_PINS        = 18;
	localparam int          OPT_WINDOW_CYC = 64;
	typedef enum logic [1:0] {
		SIRQ_IDLE = 2'b00,
		SIRQ_EXT  = 2'b01,
		SIRQ_DONE = 2'b10
	} sirq_bus_t;
endpackage : sirq_pkg

// ==== shared/sirq_opt_if.sv ====
// carrier between the register slave and the time-protected option bit
// assumes both ends run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface sirq_opt_if;
	logic wr_stb;
	logic wr_val;
	logic edge_sel;
	logic win_open;
	modport ctl  (output wr_stb, output wr_val, input edge_sel, input win_open);
	modport gate (input wr_stb, input wr_val, output edge_sel, output win_open);
endinterface : sirq_opt_if
`default_nettype wire

// ==== hdl/sirq_optgate.sv ====
// write-once edge select bit, open only for a window after reset
// assumes wr_stb is a one-cycle pulse from the register slave
`timescale 1ns/100ps
`default_nettype none
module sirq_optgate
	import sirq_pkg::*;
#(
	parameter int CYC = OPT_WINDOW_CYC
) (
	input  wire logic clk_sys,
	input  wire logic reset,
	sirq_opt_if.gate  opt
);
	localparam int CW = $clog2(CYC + 1);
	localparam logic [CW-1:0] CYC_L = CW'(CYC);
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic          used_reg;
	logic          used_next;
	logic          edge_reg;
	logic          edge_next;
	logic          open_w;

	assign open_w = (cnt_reg < CYC_L) && !used_reg;
	assign opt.win_open = open_w;
	assign opt.edge_sel = edge_reg;

	always_comb begin
		cnt_next  = cnt_reg;
		used_next = used_reg;
		edge_next = edge_reg;
		if (cnt_reg < CYC_L) begin
			cnt_next = cnt_reg + CW'(1);
		end
		// late or second writes fall through untouched
		if (opt.wr_stb && open_w) begin
			edge_next = opt.wr_val;
			used_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_reg  <= '0;
			used_reg <= 1'b0;
			edge_reg <= EDGE_RST;
		end else begin
			cnt_reg  <= cnt_next;
			used_reg <= used_next;
			edge_reg <= edge_next;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_opt_late_ignored: assert property (!open_w |=> $stable(edge_reg))
		else $error("edge select changed after its window closed");
	a_opt_window_len: assert property ((cnt_reg == CYC_L) |-> !open_w)
		else $error("option window open past its cycle count");
endmodule : sirq_optgate
`default_nettype wire

// ==== hdl/sirq_top.sv ====
// shared request pin, handshake port hand-over and on-chip flag gating
// assumes an APB master on clk_sys and asynchronous pins on irq and pio
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sirq_top
	import sirq_pkg::*;
#(
	parameter int OPT_CYC = OPT_WINDOW_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              irq_n_pin,
	input  wire logic              irq_ack,
	input  wire logic [TIMER_N-1:0] timer_evt,
	input  wire logic              rx_done,
	input  wire logic [7:0]        rx_data,
	output logic      [7:0]        tx_data,
	output logic                   tx_load,
	input  wire logic              pio_strobe_pin,
	input  wire logic [PIO_W-1:0]  pio_in,
	output logic      [PIO_W-1:0]  pio_out,
	output logic      [PIO_W-1:0]  pio_oe,
	output logic                   hs_pins_to_bus,
	output logic                   ext_req,
	output logic                   ext_we,
	output logic      [ADDR_W-1:0] ext_addr,
	output logic      [7:0]        ext_wdata,
	input  wire logic              ext_ack,
	input  wire logic [7:0]        ext_rdata,
	output logic                   shared_vec_req,
	output logic                   irq_req
);
	sirq_opt_if opt ();

	sirq_optgate #(.CYC(OPT_CYC)) u_opt (
		.clk_sys (clk_sys),
		.reset   (reset),
		.opt     (opt)
	);

	// pin synchronisers; stage one feeds only stage two
	logic       irq_s1_reg, irq_s2_reg, irq_s3_reg;
	logic       stb_s1_reg, stb_s2_reg, stb_s3_reg;
	logic [PIO_W-1:0] pin_s1_reg, pin_s2_reg;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_s1_reg <= 1'b1;
			irq_s2_reg <= 1'b1;
			irq_s3_reg <= 1'b1;
			stb_s1_reg <= 1'b1;
			stb_s2_reg <= 1'b1;
			stb_s3_reg <= 1'b1;
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
		end else begin
			irq_s1_reg <= irq_n_pin;
			irq_s2_reg <= irq_s1_reg;
			irq_s3_reg <= irq_s2_reg;
			stb_s1_reg <= pio_strobe_pin;
			stb_s2_reg <= stb_s1_reg;
			stb_s3_reg <= stb_s2_reg;
			pin_s1_reg <= pio_in;
			pin_s2_reg <= pin_s1_reg;
		end
	end

	// bus slave
	sirq_bus_t        st_reg, st_next;
	logic [31:0]      prdata_next;
	logic             pready_next, pslverr_next;
	logic             ext_req_next, ext_we_next;
	logic [ADDR_W-1:0] ext_addr_next;
	logic [7:0]       ext_wdata_next;
	logic             acc, hs_addr, go_int, wr, rd;
	logic             exp_reg, mask_reg;
	logic [TIMER_N-1:0] tflg_reg, tmsk_reg;
	logic             rdf_reg, arm_s_reg, rie_reg;
	logic             pflag_reg, arm_p_reg, pie_reg;
	logic [PIO_W-1:0] pdir_reg, pdat_reg;
	logic             irq_edge_reg;
	logic             pin_req, pio_req, sci_req, tim_req, any_req;

	assign acc     = psel && penable && (st_reg == SIRQ_IDLE);
	assign hs_addr = (paddr == A_PSTS) || (paddr == A_PDAT) || (paddr == A_PDIR);
	// handshake space belongs to the outside chip while expanded
	assign go_int  = acc && !(exp_reg && hs_addr);
	assign wr      = go_int && pwrite;
	assign rd      = go_int && !pwrite;

	always_comb begin
		st_next        = st_reg;
		prdata_next    = prdata;
		pready_next    = 1'b0;
		pslverr_next   = 1'b0;
		ext_req_next   = ext_req;
		ext_we_next    = ext_we;
		ext_addr_next  = ext_addr;
		ext_wdata_next = ext_wdata;
		case (st_reg)
			SIRQ_IDLE: begin
				if (acc && exp_reg && hs_addr) begin
					st_next        = SIRQ_EXT;
					ext_req_next   = 1'b1;
					ext_we_next    = pwrite;
					ext_addr_next  = paddr;
					ext_wdata_next = pwdata[7:0];
				end else if (acc) begin
					st_next      = SIRQ_DONE;
					pready_next  = 1'b1;
					prdata_next  = '0;
					case (paddr)
						A_CTRL: prdata_next = {30'h0, mask_reg, exp_reg};
						A_OPT:  prdata_next = {30'h0, opt.win_open, opt.edge_sel};
						A_TFLG: prdata_next = {28'h0, tflg_reg};
						A_TMSK: prdata_next = {28'h0, tmsk_reg};
						A_SSTS: prdata_next = {31'h0, rdf_reg};
						A_SDAT: prdata_next = {24'h0, rx_data};
						A_SCTL: prdata_next = {31'h0, rie_reg};
						A_PSTS: prdata_next = {30'h0, pie_reg, pflag_reg};
						A_PDAT: prdata_next = {24'h0, pin_s2_reg};
						A_PDIR: prdata_next = {24'h0, pdir_reg};
						A_PEND: prdata_next = {27'h0, pin_req, pio_req, sci_req, tim_req, irq_edge_reg};
						default: pslverr_next = 1'b1;
					endcase
				end
			end
			SIRQ_EXT: begin
				// no timeout: a silent outside chip stalls the bus
				if (ext_ack) begin
					ext_req_next = 1'b0;
					pready_next  = 1'b1;
					prdata_next  = {24'h0, ext_rdata};
					st_next      = SIRQ_DONE;
				end
			end
			SIRQ_DONE: begin
				st_next = SIRQ_IDLE;
			end
			default: begin
				st_next = SIRQ_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			st_reg    <= SIRQ_IDLE;
			prdata    <= '0;
			pready    <= 1'b0;
			pslverr   <= 1'b0;
			ext_req   <= 1'b0;
			ext_we    <= 1'b0;
			ext_addr  <= '0;
			ext_wdata <= '0;
		end else begin
			st_reg    <= st_next;
			prdata    <= prdata_next;
			pready    <= pready_next;
			pslverr   <= pslverr_next;
			ext_req   <= ext_req_next;
			ext_we    <= ext_we_next;
			ext_addr  <= ext_addr_next;
			ext_wdata <= ext_wdata_next;
		end
	end

	assign opt.wr_stb = wr && (paddr == A_OPT);
	assign opt.wr_val = pwdata[OPT_EDGE];

	// flags and control
	logic               exp_next, mask_next, rie_next, pie_next;
	logic [TIMER_N-1:0] tflg_next, tmsk_next;
	logic               rdf_next, arm_s_next, pflag_next, arm_p_next;
	logic [PIO_W-1:0]   pdir_next, pdat_next;
	logic               tx_load_next;
	logic [7:0]         tx_data_next;
	logic               rd_sdat, rd_pdat, pio_fall;

	// any read of the data register counts; a write to it does not clear
	assign rd_sdat  = rd && (paddr == A_SDAT);
	assign rd_pdat  = rd && (paddr == A_PDAT);
	assign pio_fall = stb_s3_reg && !stb_s2_reg && !exp_reg;

	always_comb begin
		exp_next     = exp_reg;
		mask_next    = mask_reg;
		tmsk_next    = tmsk_reg;
		rie_next     = rie_reg;
		pie_next     = pie_reg;
		pdir_next    = pdir_reg;
		pdat_next    = pdat_reg;
		tx_data_next = tx_data;
		tx_load_next = 1'b0;
		tflg_next    = tflg_reg;
		rdf_next     = rdf_reg;
		arm_s_next   = arm_s_reg;
		pflag_next   = pflag_reg;
		arm_p_next   = arm_p_reg;
		if (wr) begin
			case (paddr)
				A_CTRL: begin
					exp_next  = pwdata[CTRL_EXP];
					mask_next = pwdata[CTRL_MASK];
				end
				A_TFLG: tflg_next = tflg_reg & ~pwdata[TIMER_N-1:0];
				A_TMSK: tmsk_next = pwdata[TIMER_N-1:0];
				A_SCTL: rie_next  = pwdata[SCTL_RIE];
				A_SDAT: begin
					tx_data_next = pwdata[7:0];
					tx_load_next = 1'b1;
				end
				A_PSTS: pie_next  = pwdata[PSTS_IE];
				A_PDAT: pdat_next = pwdata[PIO_W-1:0];
				A_PDIR: pdir_next = pwdata[PIO_W-1:0];
				default: ;
			endcase
		end
		// serial: status read while set arms, data read clears
		if (rd && (paddr == A_SSTS) && rdf_reg) begin
			arm_s_next = 1'b1;
		end
		if (rd_sdat && arm_s_reg) begin
			rdf_next   = 1'b0;
			arm_s_next = 1'b0;
		end
		if (rd && (paddr == A_PSTS) && pflag_reg) begin
			arm_p_next = 1'b1;
		end
		if (rd_pdat && arm_p_reg) begin
			pflag_next = 1'b0;
			arm_p_next = 1'b0;
		end
		// new events win over a clear in the same cycle
		tflg_next = tflg_next | timer_evt;
		if (rx_done) begin
			rdf_next = 1'b1;
		end
		if (pio_fall) begin
			pflag_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			exp_reg   <= EXP_RST;
			mask_reg  <= MASK_RST;
			tmsk_reg  <= '0;
			rie_reg   <= 1'b0;
			pie_reg   <= 1'b0;
			pdir_reg  <= '0;
			pdat_reg  <= '0;
			tx_data   <= '0;
			tx_load   <= 1'b0;
			tflg_reg  <= '0;
			rdf_reg   <= 1'b0;
			arm_s_reg <= 1'b0;
			pflag_reg <= 1'b0;
			arm_p_reg <= 1'b0;
		end else begin
			exp_reg   <= exp_next;
			mask_reg  <= mask_next;
			tmsk_reg  <= tmsk_next;
			rie_reg   <= rie_next;
			pie_reg   <= pie_next;
			pdir_reg  <= pdir_next;
			pdat_reg  <= pdat_next;
			tx_data   <= tx_data_next;
			tx_load   <= tx_load_next;
			tflg_reg  <= tflg_next;
			rdf_reg   <= rdf_next;
			arm_s_reg <= arm_s_next;
			pflag_reg <= pflag_next;
			arm_p_reg <= arm_p_next;
		end
	end

	// request network and pins
	logic             irq_edge_next, shared_next, irq_req_next, owned_next;
	logic [PIO_W-1:0] pio_oe_next;

	assign tim_req = |(tflg_reg & tmsk_reg);
	assign sci_req = rdf_reg && rie_reg;
	assign pio_req = pflag_reg && pie_reg && !exp_reg;
	// an outside chip signals through the pin itself
	assign pin_req = opt.edge_sel ? irq_edge_reg : !irq_s2_reg;
	assign any_req = shared_next || tim_req || sci_req;

	always_comb begin
		irq_edge_next = irq_edge_reg;
		if (irq_ack) begin
			irq_edge_next = 1'b0;
		end
		// a line held low yields no fresh edge for a second source
		if (opt.edge_sel && irq_s3_reg && !irq_s2_reg) begin
			irq_edge_next = 1'b1;
		end
		shared_next  = pin_req || pio_req;
		irq_req_next = any_req && !mask_reg;
		owned_next   = exp_reg;
		pio_oe_next  = pdir_reg & {PIO_W{!exp_reg}};
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_edge_reg   <= 1'b0;
			shared_vec_req <= 1'b0;
			irq_req        <= 1'b0;
			hs_pins_to_bus <= 1'b0;
			pio_oe         <= '0;
			pio_out        <= '0;
		end else begin
			irq_edge_reg   <= irq_edge_next;
			shared_vec_req <= shared_next;
			irq_req        <= irq_req_next;
			hs_pins_to_bus <= owned_next;
			pio_oe         <= pio_oe_next;
			pio_out        <= pdat_reg;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_exp_pins_off: assert property (exp_reg |=> (pio_oe == '0) && hs_pins_to_bus)
		else $error("handshake pins still driven in expanded mode");
	a_ext_decode: assert property (acc && exp_reg && hs_addr |=> ext_req && !pready)
		else $error("handshake access not sent to external bus");
	a_shared_vec: assert property (pio_req || pin_req |=> shared_vec_req)
		else $error("shared vector request missing");
	a_edge_latch: assert property (opt.edge_sel && irq_s3_reg && !irq_s2_reg |=> irq_edge_reg)
		else $error("falling edge on request pin not latched");
	a_edge_no_new: assert property (opt.edge_sel && !irq_s3_reg && !irq_edge_reg |=> !irq_edge_reg)
		else $error("edge latched while line already low");
	a_req_gate: assert property (!any_req |=> !irq_req)
		else $error("request without an enabled flag");
	a_mask_hold: assert property (mask_reg |=> !irq_req)
		else $error("request passed the global mask");
	a_tflg_one: assert property (wr && paddr == A_TFLG && pwdata[0] && !timer_evt[0] |=> !tflg_reg[0])
		else $error("timer flag not cleared by written one");
	a_tflg_zero: assert property (wr && paddr == A_TFLG && !pwdata[0] && tflg_reg[0] |=> tflg_reg[0])
		else $error("timer flag lost on written zero");
	a_rdf_clear: assert property (rd_sdat && arm_s_reg && !rx_done |=> !rdf_reg)
		else $error("receive flag not cleared by armed data read");
	a_rdf_keep: assert property (rd_sdat && !arm_s_reg && rdf_reg |=> rdf_reg)
		else $error("receive flag cleared without a status read first");
	a_flag_steady: assert property (tim_req && !mask_reg && !wr [*2] |-> irq_req)
		else $error("enabled flag stopped requesting");

	c_rdf_serviced: cover property (rd && paddr == A_SSTS && rdf_reg ##[1:20] rd_sdat);
	c_ext_access: cover property (ext_req && ext_ack);
	c_edge_seen: cover property (opt.edge_sel && irq_s3_reg && !irq_s2_reg);
	c_masked_req: cover property (any_req && mask_reg);
endmodule : sirq_top
`default_nettype wire

// ==== verification/sirq_pru_model.sv ====
// far side: port replacement chip and a user interrupt source
// assumes the block's external handshake bus and the shared request pin
`timescale 1ns/100ps
`default_nettype none
module sirq_pru_model (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       ext_req,
	input  wire logic       ext_we,
	input  wire logic [7:0] ext_addr,
	input  wire logic [7:0] ext_wdata,
	input  wire logic       slow,
	input  wire logic       pru_irq,
	input  wire logic       src_irq,
	output logic            ext_ack,
	output logic      [7:0] ext_rdata,
	output logic            irq_n_pin
);
	logic [7:0] mem [256];
	int         cnt;
	logic       done;
	// both sources pull the one line low
	assign irq_n_pin = ~(pru_irq | src_irq);
	always @(posedge clk_sys) begin
		ext_ack <= 1'b0;
		if (reset) begin
			cnt       <= 0;
			done      <= 1'b0;
			ext_rdata <= 8'h00;
		end else if (ext_req && !done) begin
			if (cnt < (slow ? 6 : 0)) begin
				cnt <= cnt + 1;
			end else begin
				ext_ack   <= 1'b1;
				done      <= 1'b1;
				cnt       <= 0;
				ext_rdata <= mem[ext_addr];
				if (ext_we) begin
					mem[ext_addr] <= ext_wdata;
				end
			end
		end else begin
			if (!ext_req) begin
				done <= 1'b0;
			end
			// released data: never the last value
			ext_rdata <= ~ext_rdata;
		end
	end
endmodule : sirq_pru_model
`default_nettype wire

// ==== verification/test_shared_irq_and_flag_logic.sv ====
// self-checking bench of the shared interrupt block
// assumes sirq_pkg and the far-side model; 200 MHz clk_sys
`timescale 1ns/100ps
`default_nettype none
module test_shared_irq_and_flag_logic
	import sirq_pkg::*;
;
	localparam int WCYC = 16;
	logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00, rx_data = 8'h00, pio_in, tx_data, ext_addr, ext_wdata;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic        pready, pslverr, irq_n_pin, irq_ack = 0, rx_done = 0, tx_load;
	logic [3:0]  timer_evt = 4'h0, fl, en, tv, wm;
	logic        pio_strobe_pin = 1, ext_req, ext_we, ext_ack, shared_vec_req, irq_req;
	logic [7:0]  pio_out, pio_oe, ext_rdata;
	logic        hs_pins_to_bus, slow = 0, pru_irq = 0, src_irq = 0, lerr, tl;
	int          err_total = 0, compares = 0, seed = 45;
	sirq_top #(.OPT_CYC(WCYC)) i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq_n_pin(irq_n_pin), .irq_ack(irq_ack),
		.timer_evt(timer_evt), .rx_done(rx_done), .rx_data(rx_data), .tx_data(tx_data),
		.tx_load(tx_load), .pio_strobe_pin(pio_strobe_pin), .pio_in(pio_in),
		.pio_out(pio_out), .pio_oe(pio_oe), .hs_pins_to_bus(hs_pins_to_bus),
		.ext_req(ext_req), .ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
		.ext_ack(ext_ack), .ext_rdata(ext_rdata), .shared_vec_req(shared_vec_req),
		.irq_req(irq_req));
	sirq_pru_model i_pru (.clk_sys(clk_sys), .reset(reset), .ext_req(ext_req),
		.ext_we(ext_we), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .slow(slow),
		.pru_irq(pru_irq), .src_irq(src_irq), .ext_ack(ext_ack), .ext_rdata(ext_rdata),
		.irq_n_pin(irq_n_pin));
	always #2.5 clk_sys = ~clk_sys;
	function automatic logic [3:0] w1c(input logic [3:0] f, input logic [3:0] w);
		return f & ~w;
	endfunction : w1c
	task automatic stop_test;
		$display("mismatches %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	// one APB transfer; waits for pready with a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 300);
		r    = prdata;
		lerr = pslverr;
		tl   = tx_load;
		if (n >= 300) begin
			chk(32'h0, 32'h1);
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next call never re-drives psel in this step
		@(posedge clk_sys);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(r, e);
	endtask : rdc
	task automatic pend_latch(input logic e);
		apb(1'b0, A_PEND, 32'h0);
		chk({31'h0, r[0]}, {31'h0, e});
	endtask : pend_latch
	initial begin
		#(30000 * 5);
		err_total++;
		stop_test;
	end
	initial begin
		pio_in <= 8'($random(seed));
		tick(3);
		reset <= 1'b0;
		wr(A_OPT, 32'h1);
		rdc(A_OPT, 32'h1);
		wr(A_OPT, 32'h0);
		rdc(A_OPT, 32'h1);
		rdc(A_CTRL, 32'h2);
		apb(1'b0, 8'h3C, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, lerr}, 32'h1);
		src_irq <= 1'b1;
		tick(6);
		pend_latch(1'b1);
		chk({31'h0, shared_vec_req}, 32'h1);
		irq_ack <= 1'b1;
		tick(1);
		irq_ack <= 1'b0;
		pru_irq <= 1'b1;
		tick(6);
		pend_latch(1'b0);
		src_irq <= 1'b0;
		pru_irq <= 1'b0;
		tick(4);
		pru_irq <= 1'b1;
		tick(6);
		pend_latch(1'b1);
		pru_irq <= 1'b0;
		irq_ack <= 1'b1;
		tick(1);
		irq_ack <= 1'b0;
		tick(4);
		rdc(A_OPT, 32'h1);
		wr(A_TMSK, 32'hF);
		timer_evt <= 4'hF;
		tick(1);
		timer_evt <= 4'h0;
		tick(3);
		chk({31'h0, irq_req}, 32'h0);
		wr(A_CTRL, 32'h0);
		tick(2);
		chk({31'h0, irq_req}, 32'h1);
		fl = 4'hF;
		// corner: zeros in the written word must keep their flags
		wr(A_TFLG, 32'hE);
		fl = w1c(fl, 4'hE);
		rdc(A_TFLG, {28'h0, fl});
		for (int i = 0; i < 6; i++) begin
			tv = 4'($random(seed));
			wm = 4'($random(seed));
			en = 4'($random(seed));
			wr(A_TMSK, {28'h0, en});
			timer_evt <= tv;
			tick(1);
			timer_evt <= 4'h0;
			fl = fl | tv;
			rdc(A_TFLG, {28'h0, fl});
			wr(A_TFLG, {28'h0, wm});
			fl = w1c(fl, wm);
			rdc(A_TFLG, {28'h0, fl});
			tick(1);
			chk({31'h0, irq_req}, {31'h0, |(fl & en)});
		end
		wr(A_TFLG, 32'hF);
		wr(A_SCTL, 32'h1);
		rx_data <= 8'($random(seed));
		rx_done <= 1'b1;
		tick(1);
		rx_done <= 1'b0;
		tick(2);
		chk({31'h0, irq_req}, 32'h1);
		rdc(A_SDAT, {24'h0, rx_data});
		rdc(A_SSTS, 32'h1);
		tick(8);
		chk({31'h0, irq_req}, 32'h1);
		rdc(A_SDAT, {24'h0, rx_data});
		wr(A_SDAT, 32'h0);
		chk({24'h0, tx_data}, 32'h0);
		chk({31'h0, tl}, 32'h1);
		rdc(A_SSTS, 32'h0);
		chk({31'h0, irq_req}, 32'h0);
		wr(A_PSTS, 32'h2);
		pio_strobe_pin <= 1'b0;
		tick(6);
		chk({31'h0, shared_vec_req}, 32'h1);
		rdc(A_PSTS, 32'h3);
		rdc(A_PDAT, {24'h0, pio_in});
		rdc(A_PSTS, 32'h2);
		wr(A_PDIR, 32'hFF);
		wr(A_PDAT, 32'h5A);
		tick(1);
		chk({24'h0, pio_oe}, 32'hFF);
		chk({24'h0, pio_out}, 32'h5A);
		wr(A_CTRL, 32'h1);
		tick(2);
		chk({31'h0, hs_pins_to_bus}, 32'h1);
		chk({24'h0, pio_oe}, 32'h0);
		wr(A_PDAT, 32'hA5);
		chk({24'h0, pio_out}, 32'h5A);
		rdc(A_PDAT, 32'hA5);
		slow <= 1'b1;
		wr(A_PDIR, 32'h3C);
		rdc(A_PDIR, 32'h3C);
		// second reset in mid-run: edge select must fall back to level
		reset <= 1'b1;
		tick(3);
		reset <= 1'b0;
		rdc(A_OPT, 32'h2);
		tick(WCYC + 4);
		wr(A_OPT, 32'h1);
		rdc(A_OPT, 32'h0);
		pru_irq <= 1'b1;
		tick(6);
		chk({31'h0, shared_vec_req}, 32'h1);
		pru_irq <= 1'b0;
		tick(6);
		chk({31'h0, shared_vec_req}, 32'h0);
		stop_test;
	end
endmodule : test_shared_irq_and_flag_logic
`default_nettype wire
